// >>> src/refresh_pkg.sv
package refresh_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_LUT_ADDR = 8'h0A;
	localparam logic [7:0] IDX_LUT_RED = 8'h0C;
	localparam logic [7:0] IDX_LUT_GREEN = 8'h0D;
	localparam logic [7:0] IDX_LUT_BLUE = 8'h0E;
	localparam logic [7:0] IDX_HTOTAL = 8'h12;
	localparam logic [7:0] IDX_VTOTAL_LO = 8'h18;
	localparam logic [7:0] IDX_VTOTAL_HI = 8'h19;
	localparam logic [7:0] IDX_DISP_MODE = 8'h70;
	localparam logic [7:0] IDX_MODE_ROT = 8'h71;
	localparam logic [7:0] IDX_MAIN_SA0 = 8'h74;
	localparam logic [7:0] IDX_MAIN_SA1 = 8'h75;
	localparam logic [7:0] IDX_MAIN_SA2 = 8'h76;
	localparam logic [7:0] IDX_MAIN_LO_LO = 8'h78;
	localparam logic [7:0] IDX_MAIN_LO_HI = 8'h79;
	localparam logic [7:0] IDX_OV_FIRST = 8'h7C;
	localparam logic [7:0] IDX_OV_SA0 = 8'h7C;
	localparam logic [7:0] IDX_OV_SA1 = 8'h7D;
	localparam logic [7:0] IDX_OV_SA2 = 8'h7E;
	localparam logic [7:0] IDX_OV_LO_LO = 8'h80;
	localparam logic [7:0] IDX_OV_LO_HI = 8'h81;
	localparam logic [7:0] IDX_OV_XS_LO = 8'h84;
	localparam logic [7:0] IDX_OV_XS_HI = 8'h85;
	localparam logic [7:0] IDX_OV_XE_LO = 8'h88;
	localparam logic [7:0] IDX_OV_XE_HI = 8'h89;
	localparam logic [7:0] IDX_OV_YS_LO = 8'h8C;
	localparam logic [7:0] IDX_OV_YS_HI = 8'h8D;
	localparam logic [7:0] IDX_OV_YE_LO = 8'h90;
	localparam logic [7:0] IDX_OV_YE_HI = 8'h91;
	localparam logic [7:0] IDX_OV_LAST = 8'h91;
	localparam logic [7:0] IDX_PWR = 8'hA0;
	localparam logic [7:0] IDX_STAT_LO = 8'hA2;
	localparam logic [7:0] IDX_STAT_HI = 8'hA3;
	localparam int REG_COUNT = 256;
	localparam int ADDR_W = 10;
	// field positions
	localparam int HT_MSB = 6;
	localparam int ROT_MSB = 1;
	localparam int ROT_LSB = 0;
	localparam int OV_EN_BIT = 4;
	localparam int BPP_MSB = 2;
	localparam int INVERT_BIT = 4;
	localparam int MONO_BIT = 6;
	localparam int PWR_SAVE_BIT = 0;
	localparam int UNDERRUN_BIT = 7;
	// reset values and the 16 bpp depth code
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [7:0] RST_PWR = 8'h01;
	localparam logic [2:0] BPP16_CODE = 3'h4;
	// pixel clock derived from the 4 ns bus clock
	localparam int CLK_PERIOD_NS = 4;
	localparam int PIX_PERIOD_NS = 16;
	localparam int PIX_DIV = (PIX_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PA_W = 22;
	localparam int WA_W = 17;
	localparam int LUT_DEPTH = 256;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		ROT_0 = 2'b00, ROT_90 = 2'b01, ROT_180 = 2'b10, ROT_270 = 2'b11
	} rot_t;
	typedef enum logic [1:0] {
		F_IDLE = 2'b00, F_REQ = 2'b01, F_HOLD = 2'b10
	} fetch_state_t;
endpackage

// >>> src/pixel_path_if.sv
`timescale 1ns/1ns
`default_nettype none
interface pixel_path_if;
	logic valid;
	logic [31:0] word;
	logic [4:0] sub;
	logic [2:0] bpp;
	logic mono;
	logic invert;
	logic blank;
	logic lut_we;
	logic [7:0] lut_addr;
	logic [23:0] lut_data;
	logic out_valid;
	logic [7:0] r;
	logic [7:0] g;
	logic [7:0] b;
	modport src (output valid, word, sub, bpp, mono, invert, blank, lut_we,
		lut_addr, lut_data, input out_valid, r, g, b);
	modport dst (input valid, word, sub, bpp, mono, invert, blank, lut_we,
		lut_addr, lut_data, output out_valid, r, g, b);
endinterface
`default_nettype wire

// >>> src/pixel_colour_path.sv
`timescale 1ns/1ns
`default_nettype none
module pixel_colour_path
	import refresh_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// pixel stream and table writes
	pixel_path_if.dst pp
);
	logic [23:0] lut_r [LUT_DEPTH];
	logic [23:0] lut_hit;
	logic [4:0] lsb;
	logic [15:0] pix;
	logic [15:0] pix_mask;
	logic [7:0] r_nxt;
	logic [7:0] g_nxt;
	logic [7:0] b_nxt;

	// little-endian bytes, first pixel of a byte in its high bits
	function automatic logic [4:0] pixel_lsb(input logic [2:0] bpp,
		input logic [4:0] sub);
		logic [2:0] lg;
		logic [4:0] k;
		lg = 3'd3 - bpp;
		k = sub & 5'((5'd1 << lg) - 5'd1);
		if (bpp == BPP16_CODE)
			return {sub[0], 4'h0};
		return 5'((sub >> lg) << 3) + 5'd8 - 5'((k + 5'd1) << bpp);
	endfunction

	always_comb begin
		lsb = pixel_lsb(pp.bpp, pp.sub);
		pix_mask = 16'((32'd1 << (32'd1 << pp.bpp)) - 32'd1);
		pix = 16'(pp.word >> lsb) & pix_mask;
		lut_hit = lut_r[pix[7:0]];
		if (pp.bpp == BPP16_CODE && pp.mono) begin
			r_nxt = {pix[10:5], pix[10:9]}; // [RL4]
			g_nxt = r_nxt;
			b_nxt = r_nxt;
		end else if (pp.bpp == BPP16_CODE) begin
			r_nxt = {pix[15:11], pix[15:13]}; // [RL5]
			g_nxt = {pix[10:5], pix[10:9]};
			b_nxt = {pix[4:0], pix[4:2]};
		end else if (pp.mono) begin
			r_nxt = lut_hit[15:8]; // [RL3]
			g_nxt = lut_hit[15:8];
			b_nxt = lut_hit[15:8];
		end else begin
			r_nxt = lut_hit[23:16];
			g_nxt = lut_hit[15:8];
			b_nxt = lut_hit[7:0];
		end
		// inversion sits after the table so the table holds true colours
		if (pp.invert) begin
			r_nxt = ~r_nxt; // [RL2]
			g_nxt = ~g_nxt;
			b_nxt = ~b_nxt;
		end
	end

	always_ff @(posedge aclk) begin
		if (pp.lut_we)
			lut_r[pp.lut_addr] <= pp.lut_data;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || pp.blank) begin
			pp.out_valid <= 1'b0;
			pp.r <= 8'h00;
			pp.g <= 8'h00;
			pp.b <= 8'h00;
		end else begin
			pp.out_valid <= pp.valid;
			if (pp.valid) begin
				pp.r <= r_nxt;
				pp.g <= g_nxt;
				pp.b <= b_nxt;
			end
		end
	end

	chk_invert_after_table: assert property (@(posedge aclk) disable iff (!aresetn) // [RL2]
		pp.valid && !pp.blank && pp.invert && !pp.mono && pp.bpp != BPP16_CODE
		|=> pp.g == ~$past(lut_hit[15:8]))
		else $error("inversion not applied after the colour table");
	chk_mono_green_only: assert property (@(posedge aclk) disable iff (!aresetn) // [RL3]
		pp.valid && !pp.blank && pp.mono && !pp.invert && pp.bpp != BPP16_CODE
		|=> pp.r == $past(lut_hit[15:8]) && pp.b == pp.g && pp.r == pp.g)
		else $error("monochrome pixel not taken from green table");
	chk_direct_colour: assert property (@(posedge aclk) disable iff (!aresetn) // [RL5]
		pp.valid && !pp.blank && !pp.mono && !pp.invert && pp.bpp == BPP16_CODE
		|=> pp.r[7:3] == $past(pix[15:11]) && pp.b[7:3] == $past(pix[4:0]))
		else $error("16 bpp colour not passed through directly");
endmodule
`default_nettype wire

// >>> src/display_refresh_rotation.sv
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// [RL1] frame lasts horizontal total times vertical total pixel clocks
// [RL2] inversion is applied after the colour table output
// [RL3] monochrome modes use only the green table
// [RL4] 16 bpp monochrome bypasses the table, green drives the output
// [RL5] 16 bpp colour bypasses the table, red green blue pass directly
// [RL6] rotation affects only refresh fetches; host accesses stay untranslated
// [RL7] rotation select 01, 10, 11 picks 90, 180, 270 degrees
// [RL8] rotation select 00 gives plain left-right, top-bottom refresh
// [RL9] system supplies memory clock at least 1.25 times pixel clock
// [RL10] 90 degrees starts top-right, order B D A C
// [RL11] 180 degrees starts at last pixel, order D C B A
// [RL12] 270 degrees starts bottom-left, order C A D B
// [RL13] refresh starts at the 17-bit word start address
// [RL14] refresh steps lines by the 10-bit word line offset
// [RL15] a secondary window overlays the main window anywhere
// [RL16] secondary window shares colour depth and rotation
// [RL17] secondary window registers live at indices 7Ch to 91h
// [RL18] power save stops panel output and refresh fetches
module display_refresh_rotation
	import refresh_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write channels
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read channels
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// refresh fetch port
	output logic mem_req,
	output logic [WA_W-1:0] mem_addr,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	// panel
	output logic panel_on,
	output logic pix_valid,
	output logic [7:0] pix_r,
	output logic [7:0] pix_g,
	output logic [7:0] pix_b,
	output logic line_start,
	output logic frame_start
);
	logic [7:0] reg_r [REG_COUNT];
	logic aw_held_r;
	logic w_held_r;
	logic [7:0] aw_idx_r;
	logic [7:0] wbyte_r;
	logic wlane_r;
	logic wr_go;
	logic [7:0] ar_idx;
	logic [7:0] rbyte;
	logic underrun_r;
	logic [$clog2(PIX_DIV+1)-1:0] div_r;
	logic tick;
	logic [9:0] x_r;
	logic [9:0] y_r;
	logic x_last;
	logic y_last;
	logic ps;
	rot_t rot;
	logic [2:0] bpp;
	logic [2:0] shift;
	logic [9:0] h_last;
	logic [9:0] v_last;
	logic [WA_W-1:0] main_sa;
	logic [WA_W-1:0] ov_sa;
	logic [9:0] main_offs;
	logic [9:0] ov_offs;
	logic in_win;
	logic y_in_win;
	logic [PA_W-1:0] main_line_r;
	logic [PA_W-1:0] main_pa_r;
	logic [PA_W-1:0] ov_line_r;
	logic [PA_W-1:0] ov_pa_r;
	logic [PA_W-1:0] fetch_pa;
	fetch_state_t fstate_r;
	logic miss_r;
	logic [31:0] word_r;
	logic [4:0] fetch_sub_r;
	logic line_start_r;
	logic frame_start_r;
	pixel_path_if pif ();

	function automatic logic writable(input logic [7:0] idx);
		if (idx == IDX_HTOTAL || idx == IDX_VTOTAL_LO || idx == IDX_VTOTAL_HI)
			return 1'b1;
		else if (idx == IDX_DISP_MODE || idx == IDX_MODE_ROT || idx == IDX_PWR)
			return 1'b1;
		else if (idx >= IDX_MAIN_SA0 && idx <= IDX_MAIN_SA2)
			return 1'b1;
		else if (idx == IDX_MAIN_LO_LO || idx == IDX_MAIN_LO_HI)
			return 1'b1;
		else if (idx >= IDX_OV_FIRST && idx <= IDX_OV_LAST)
			return 1'b1; // [RL17]
		else if (idx == IDX_LUT_ADDR)
			return 1'b1;
		else if (idx >= IDX_LUT_RED && idx <= IDX_LUT_BLUE)
			return 1'b1;
		else
			return 1'b0;
	endfunction

	function automatic logic [9:0] fld10(input logic [7:0] lo,
		input logic [7:0] hi);
		return {hi[1:0], lo};
	endfunction

	// pixel address = word address shifted left by log2(pixels per word)
	function automatic logic [PA_W-1:0] start_pa(input logic [WA_W-1:0] sa,
		input rot_t r, input logic [2:0] sh);
		logic [PA_W-1:0] base;
		base = PA_W'(sa) << sh;
		if (r == ROT_90 || r == ROT_180)
			base = base | PA_W'((22'd1 << sh) - 22'd1);
		return base;
	endfunction

	function automatic logic [PA_W-1:0] step_pa(input logic [PA_W-1:0] pa,
		input rot_t r, input logic is_line, input logic [9:0] offs,
		input logic [2:0] sh);
		logic [PA_W-1:0] big;
		big = PA_W'(offs) << sh;
		case ({is_line, r})
			{1'b0, ROT_0}: return pa + 22'd1; // [RL8]
			{1'b0, ROT_90}: return pa + big; // [RL10]
			{1'b0, ROT_180}: return pa - 22'd1; // [RL11]
			{1'b0, ROT_270}: return pa - big; // [RL12]
			{1'b1, ROT_0}: return pa + big; // [RL14]
			{1'b1, ROT_90}: return pa - 22'd1;
			{1'b1, ROT_180}: return pa - big;
			default: return pa + 22'd1;
		endcase
	endfunction

	// mode decode; the overlay window reuses depth and rotation
	assign ps = reg_r[IDX_PWR][PWR_SAVE_BIT];
	assign rot = rot_t'(reg_r[IDX_MODE_ROT][ROT_MSB:ROT_LSB]); // [RL7] [RL16]
	assign bpp = (reg_r[IDX_DISP_MODE][BPP_MSB:0] > BPP16_CODE) ? BPP16_CODE :
		reg_r[IDX_DISP_MODE][BPP_MSB:0];
	assign shift = 3'd5 - bpp;
	assign h_last = {reg_r[IDX_HTOTAL][HT_MSB:0], 3'b111}; // [RL1]
	assign v_last = fld10(reg_r[IDX_VTOTAL_LO], reg_r[IDX_VTOTAL_HI]);
	assign main_sa = {reg_r[IDX_MAIN_SA2][0], reg_r[IDX_MAIN_SA1],
		reg_r[IDX_MAIN_SA0]};
	assign ov_sa = {reg_r[IDX_OV_SA2][0], reg_r[IDX_OV_SA1], reg_r[IDX_OV_SA0]};
	assign main_offs = fld10(reg_r[IDX_MAIN_LO_LO], reg_r[IDX_MAIN_LO_HI]);
	assign ov_offs = fld10(reg_r[IDX_OV_LO_LO], reg_r[IDX_OV_LO_HI]);
	assign y_in_win = reg_r[IDX_MODE_ROT][OV_EN_BIT]
		&& y_r >= fld10(reg_r[IDX_OV_YS_LO], reg_r[IDX_OV_YS_HI])
		&& y_r <= fld10(reg_r[IDX_OV_YE_LO], reg_r[IDX_OV_YE_HI]);
	assign in_win = y_in_win
		&& x_r >= fld10(reg_r[IDX_OV_XS_LO], reg_r[IDX_OV_XS_HI])
		&& x_r <= fld10(reg_r[IDX_OV_XE_LO], reg_r[IDX_OV_XE_HI]); // [RL15]

	// axi4-lite slave: address and data taken in either order
	assign awready = !aw_held_r;
	assign wready = !w_held_r;
	assign arready = !rvalid;
	assign wr_go = aw_held_r && w_held_r && !bvalid;
	assign ar_idx = araddr[ADDR_W-1:2];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_idx_r <= 8'h00;
			wbyte_r <= 8'h00;
			wlane_r <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_held_r <= 1'b1;
				aw_idx_r <= awaddr[ADDR_W-1:2];
			end
			if (wvalid && wready) begin
				w_held_r <= 1'b1;
				wbyte_r <= wdata[7:0];
				wlane_r <= wstrb[0];
			end
			if (wr_go) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				bvalid <= 1'b1;
				bresp <= (writable(aw_idx_r) || aw_idx_r == IDX_STAT_HI) ?
					RESP_OKAY : RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// host display-buffer traffic never passes here, so it stays unrotated
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < REG_COUNT; i++)
				reg_r[i] <= RST_REG;
			reg_r[IDX_PWR] <= RST_PWR;
		end else if (wr_go && wlane_r && writable(aw_idx_r)) begin
			reg_r[aw_idx_r] <= wbyte_r; // [RL6]
		end
	end

	always_comb begin
		if (ar_idx == IDX_STAT_LO)
			rbyte = y_r[7:0];
		else if (ar_idx == IDX_STAT_HI)
			rbyte = {underrun_r, 5'h00, y_r[9:8]};
		else if (writable(ar_idx))
			rbyte = reg_r[ar_idx];
		else
			rbyte = 8'h00;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata <= {24'h00_0000, rbyte};
			rresp <= (writable(ar_idx) || ar_idx == IDX_STAT_LO
				|| ar_idx == IDX_STAT_HI) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

	// pixel clock and raster counters
	assign tick = !ps && div_r == ($bits(div_r))'(PIX_DIV - 1);
	assign x_last = x_r == h_last;
	assign y_last = y_r == v_last;

	always_ff @(posedge aclk) begin
		if (!aresetn || ps) begin
			div_r <= '0;
			x_r <= 10'h000;
			y_r <= 10'h000;
		end else begin
			div_r <= tick ? '0 : div_r + 1'b1;
			if (tick) begin
				x_r <= x_last ? 10'h000 : x_r + 10'h001; // [RL1]
				if (x_last)
					y_r <= y_last ? 10'h000 : y_r + 10'h001;
			end
		end
	end

	// refresh pointers, stepped by shifts so no multiplier is needed
	always_ff @(posedge aclk) begin
		if (!aresetn || ps || (tick && x_last && y_last)) begin
			main_line_r <= start_pa(main_sa, rot, shift); // [RL13]
			main_pa_r <= start_pa(main_sa, rot, shift);
			ov_line_r <= start_pa(ov_sa, rot, shift);
			ov_pa_r <= start_pa(ov_sa, rot, shift);
		end else if (tick && x_last) begin
			main_line_r <= step_pa(main_line_r, rot, 1'b1, main_offs, shift);
			main_pa_r <= step_pa(main_line_r, rot, 1'b1, main_offs, shift);
			if (y_in_win) begin
				ov_line_r <= step_pa(ov_line_r, rot, 1'b1, ov_offs, shift);
				ov_pa_r <= step_pa(ov_line_r, rot, 1'b1, ov_offs, shift);
			end else begin
				ov_pa_r <= ov_line_r;
			end
		end else if (tick) begin
			main_pa_r <= step_pa(main_pa_r, rot, 1'b0, main_offs, shift);
			if (in_win)
				ov_pa_r <= step_pa(ov_pa_r, rot, 1'b0, ov_offs, shift);
		end
	end

	assign fetch_pa = in_win ? ov_pa_r : main_pa_r;
	assign mem_req = fstate_r == F_REQ;

	// one word fetched per pixel; the memory must keep up with the raster
	always_ff @(posedge aclk) begin
		if (!aresetn || ps) begin
			fstate_r <= F_IDLE; // [RL18]
			miss_r <= 1'b0;
			mem_addr <= '0;
			fetch_sub_r <= 5'h00;
			word_r <= 32'h0000_0000;
		end else begin
			case (fstate_r)
				F_IDLE: begin
					mem_addr <= WA_W'(fetch_pa >> shift);
					fetch_sub_r <= fetch_pa[4:0] & 5'((5'd1 << shift) - 5'd1);
					miss_r <= 1'b0;
					fstate_r <= F_REQ;
				end
				F_REQ: begin
					if (tick)
						miss_r <= 1'b1;
					if (mem_ack) begin
						word_r <= mem_rdata;
						// a missed slot restarts so the stream stays aligned
						fstate_r <= (miss_r || tick) ? F_IDLE : F_HOLD;
					end
				end
				F_HOLD: begin
					if (tick)
						fstate_r <= F_IDLE;
				end
				default: fstate_r <= F_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			underrun_r <= 1'b0;
		end else if (tick && fstate_r != F_HOLD) begin
			underrun_r <= 1'b1;
		end else if (wr_go && wlane_r && aw_idx_r == IDX_STAT_HI
			&& wbyte_r[UNDERRUN_BIT]) begin
			underrun_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || ps) begin
			line_start_r <= 1'b0;
			frame_start_r <= 1'b0;
		end else begin
			line_start_r <= tick && x_r == 10'h000;
			frame_start_r <= tick && x_r == 10'h000 && y_r == 10'h000;
		end
	end

	assign pif.valid = tick;
	assign pif.word = word_r;
	assign pif.sub = fetch_sub_r;
	assign pif.bpp = bpp;
	assign pif.mono = reg_r[IDX_DISP_MODE][MONO_BIT];
	assign pif.invert = reg_r[IDX_DISP_MODE][INVERT_BIT];
	assign pif.blank = ps;
	assign pif.lut_we = wr_go && wlane_r && aw_idx_r == IDX_LUT_BLUE;
	assign pif.lut_addr = reg_r[IDX_LUT_ADDR];
	assign pif.lut_data = {reg_r[IDX_LUT_RED], reg_r[IDX_LUT_GREEN], wbyte_r};

	pixel_colour_path u_colour (
		.aclk(aclk),
		.aresetn(aresetn),
		.pp(pif)
	);

	assign panel_on = !ps; // [RL18]
	assign pix_valid = pif.out_valid;
	assign pix_r = pif.r;
	assign pix_g = pif.g;
	assign pix_b = pif.b;
	assign line_start = line_start_r;
	assign frame_start = frame_start_r;

	chk_ps_no_fetch: assert property (@(posedge aclk) disable iff (!aresetn) // [RL18]
		ps |=> !mem_req && !pix_valid)
		else $error("fetch or pixel seen in power save");
	chk_frame_wrap: assert property (@(posedge aclk) disable iff (!aresetn) // [RL1]
		tick && x_last && y_last |=> x_r == 10'h000 && y_r == 10'h000
		&& main_pa_r == start_pa(main_sa, rot, shift))
		else $error("frame did not wrap to the start address");
	chk_line_wrap: assert property (@(posedge aclk) disable iff (!aresetn) // [RL1]
		tick && x_last && !y_last |=> x_r == 10'h000
		&& y_r == $past(y_r) + 10'h001)
		else $error("line did not end at horizontal total");
	chk_pixel_spacing: assert property (@(posedge aclk) disable iff (!aresetn) // [RL1]
		tick |=> !tick [*3])
		else $error("pixel clock faster than divider");
	chk_rot0_step: assert property (@(posedge aclk) disable iff (!aresetn) // [RL8]
		tick && !x_last && rot == ROT_0 && !ps ##1 !ps
		|-> main_pa_r == $past(main_pa_r) + 22'd1)
		else $error("plain refresh did not advance by one pixel");
	chk_rot180_step: assert property (@(posedge aclk) disable iff (!aresetn) // [RL11]
		tick && !x_last && rot == ROT_180 && !ps ##1 !ps
		|-> main_pa_r == $past(main_pa_r) - 22'd1)
		else $error("180 refresh did not walk backwards");
	chk_rot90_line: assert property (@(posedge aclk) disable iff (!aresetn) // [RL10]
		tick && x_last && !y_last && rot == ROT_90 && !ps ##1 !ps
		|-> main_line_r == $past(main_line_r) - 22'd1)
		else $error("90 refresh line did not move one pixel left");
	chk_rot270_along: assert property (@(posedge aclk) disable iff (!aresetn) // [RL12]
		tick && !x_last && rot == ROT_270 && !ps ##1 !ps
		|-> main_pa_r == $past(main_pa_r) - (PA_W'(main_offs) << shift))
		else $error("270 refresh did not climb one stored line");
	chk_line_offset: assert property (@(posedge aclk) disable iff (!aresetn) // [RL14]
		tick && x_last && !y_last && rot == ROT_0 && !ps ##1 !ps
		|-> main_line_r == $past(main_line_r) + (PA_W'(main_offs) << shift))
		else $error("line step differs from line offset");
	chk_overlay_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [RL15]
		tick && !x_last && !in_win && !ps ##1 !ps |-> $stable(ov_pa_r))
		else $error("overlay pointer moved outside the window");
endmodule
`default_nettype wire

// >>> tb/panel_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module panel_mem_model
	import refresh_pkg::*;
(
	// clock and pacing
	input wire logic aclk,
	input wire logic slow,
	// refresh fetch port
	input wire logic mem_req,
	input wire logic [WA_W-1:0] mem_addr,
	output logic mem_ack,
	output logic [31:0] mem_rdata
);
	logic ack_r = 1'b0;
	logic [31:0] idle_r = 32'h0;
	// fast answers in the request cycle, slow one cycle later; the slow ack
	// lands a cycle before the pixel tick, so both memories keep up
	assign mem_ack = slow ? ack_r : mem_req;
	// released data bus toggles so stale words never look valid
	assign mem_rdata = mem_ack ?
		{mem_addr[15:0] ^ 16'h5A5A, ~mem_addr[15:0]} : idle_r;
	always_ff @(posedge aclk) begin
		ack_r <= mem_req && !ack_r;
		idle_r <= ~idle_r;
	end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
	import refresh_pkg::*;
;
	localparam int NPIX = 16;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow;
	logic awready, wready, bvalid, arready, rvalid, mem_req, mem_ack;
	logic panel_on, pix_valid, line_start, frame_start, inv, mono;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata, mem_rdata, w;
	logic [1:0] bresp, rresp;
	logic [WA_W-1:0] mem_addr;
	logic [7:0] pix_r, pix_g, pix_b;
	logic [15:0] p;
	logic [23:0] c;
	logic [34:0] rq[$];
	logic [1:0] bq[$];
	logic [25:0] pq[$];
	logic [WA_W-1:0] fq[$];
	logic [7:0] cfg[10];
	logic [7:0] ri[10] = '{IDX_DISP_MODE, IDX_MODE_ROT, IDX_MAIN_SA0,
		IDX_MAIN_SA1, IDX_MAIN_SA2, IDX_MAIN_LO_LO, IDX_MAIN_LO_HI,
		IDX_HTOTAL, IDX_VTOTAL_LO, IDX_VTOTAL_HI};
	int n_errors = 0, n_checks = 0, cyc = 0, last = -1;
	int r, x, y, a, s, sa, n, k;

	display_refresh_rotation dut (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .mem_req(mem_req),
		.mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.panel_on(panel_on), .pix_valid(pix_valid), .pix_r(pix_r),
		.pix_g(pix_g), .pix_b(pix_b), .line_start(line_start),
		.frame_start(frame_start));
	panel_mem_model mem (.aclk(aclk), .slow(slow), .mem_req(mem_req),
		.mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	task automatic summarize;
		if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic cmp(input logic [34:0] got, input logic [34:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic guard(input bit t);
		if (t) begin
			n_errors++;
			$display("mismatch at %0t: timeout", $time);
			summarize();
		end
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d,
		input logic [1:0] er);
		int m = 0;
		bit got = 1'b0;
		bq.push_back(er);
		awaddr <= {i, 2'h0};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			got = bvalid;
			m++;
		end while (m < 300 && !got);
		guard(!got);
	endtask
	task automatic rd(input logic [7:0] i, input logic [34:0] e);
		int m = 0;
		bit got = 1'b0;
		rq.push_back(e);
		araddr <= {i, 2'h0};
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			got = rvalid;
			m++;
		end while (m < 300 && !got);
		guard(!got);
	endtask

	// results are paired with the oldest note of their kind
	always @(posedge aclk) begin
		cyc++;
		if (aresetn) begin
			if (bvalid && bready && bq.size() > 0)
				cmp(35'(bresp), 35'(bq.pop_front()));
			if (rvalid && rready && rq.size() > 0) begin
				cmp({rq[0][34], rresp, rdata & {32{rq[0][34]}}}, rq[0]);
				void'(rq.pop_front());
			end
			if (mem_req && mem_ack && fq.size() > 0)
				cmp(35'(mem_addr), 35'(fq.pop_front()));
			if (pix_valid && pq.size() > 0)
				cmp({frame_start, line_start, pix_r, pix_g, pix_b},
					35'(pq.pop_front()));
			if (!panel_on) last = -1;
			else if (pix_valid && frame_start) begin
				if (last >= 0) cmp(35'(cyc - last), 35'(NPIX * PIX_DIV));
				last = cyc;
			end
		end
	end

	initial begin
		// responses are always accepted, so bready and rready stay high
		{awvalid, wvalid, bready, arvalid, rready, slow, aresetn} = 7'h14;
		{awaddr, araddr, wdata} = '0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		void'($urandom(77531));
		rd(IDX_PWR, {1'b1, RESP_OKAY, 24'h0, RST_PWR});
		rd(IDX_MODE_ROT, {1'b1, RESP_OKAY, 24'h0, RST_REG});
		wr(IDX_OV_FIRST, 8'hA5, RESP_OKAY);
		rd(IDX_OV_FIRST, {1'b1, RESP_OKAY, 32'hA5});
		wr(IDX_OV_LAST, 8'h03, RESP_OKAY);
		rd(IDX_OV_LAST, {1'b1, RESP_OKAY, 32'h03});
		wr(8'h05, 8'h11, RESP_SLVERR);
		rd(8'h05, {1'b0, RESP_SLVERR, 32'h0});
		for (r = 0; r < 4; r++) begin
			sa = 32'h200 + int'($urandom % 256);
			inv = 1'($urandom % 2);
			mono = r[1];
			slow <= r[0];
			// 8 x 2 panel at 16 bpp, four words per stored line
			cfg = '{{1'b0, mono, 1'b0, inv, 1'b0, BPP16_CODE},
				{6'h0, 2'(r)}, 8'(sa),
				8'(sa >> 8), 8'(sa >> 16), 8'h04, 8'h00, 8'h00, 8'h01, 8'h00};
			foreach (ri[j]) wr(ri[j], cfg[j], RESP_OKAY);
			for (y = 0; y < 2; y++) for (x = 0; x < 8; x++) begin
				case (r)
					0: begin a = sa + y * 4 + x / 2; s = x % 2; end
					1: begin a = sa + x * 4 - y / 2; s = 1 - y % 2; end
					2: begin a = sa - y * 4 - x / 2; s = 1 - x % 2; end
					default: begin a = sa - x * 4 + y / 2; s = y % 2; end
				endcase
				w = {a[15:0] ^ 16'h5A5A, ~a[15:0]};
				p = s[0] ? w[31:16] : w[15:0];
				c = {p[15:11], p[15:13], p[10:5], p[10:9], p[4:0], p[4:2]};
				if (mono) c = {3{p[10:5], p[10:9]}};
				fq.push_back(WA_W'(a));
				pq.push_back({x == 0 && y == 0, x == 0, c ^ {24{inv}}});
			end
			wr(IDX_PWR, 8'h00, RESP_OKAY);
			for (n = 0; n < 2000 && pq.size() > 0; n++) @(posedge aclk);
			guard(pq.size() > 0);
			// let the next frame start so its period is measured
			repeat (70) @(posedge aclk);
			wr(IDX_PWR, 8'h01, RESP_OKAY);
			repeat (8) @(posedge aclk);
			k = 0;
			repeat (40) begin
				@(posedge aclk);
				if (mem_req) k++;
			end
			cmp(35'(k), 35'(0));
			cmp(35'(panel_on), 35'(0));
			fq.delete();
		end
		summarize();
	end
endmodule
`default_nettype wire
